// file: sbl_pkg.sv
// shared constants and types for the battery log LED sequencer
package sbl_pkg;
    localparam int CLK_HZ   = 100_000_000;
    localparam int BAUD     = 115200;
    localparam int BAUD_DIV = CLK_HZ / BAUD;
    localparam int MS_CYC   = CLK_HZ / 1000;

    localparam int BOOT_S      = 3;
    localparam int BOOT_MS     = BOOT_S * 1000;
    localparam int READ_MIN_S  = 8;
    localparam int READ_MIN_MS = READ_MIN_S * 1000;
    localparam int READ_MAX_S  = 300;
    localparam int READ_MAX_MS = READ_MAX_S * 1000;
    localparam int FADE_S      = 1;
    localparam int FADE_MS     = FADE_S * 1000;
    localparam int FLASH_MS    = 100;

    localparam logic [12:0] MV_FLASH1 = 13'd4900;
    localparam logic [12:0] MV_FLASH2 = 13'd4800;
    localparam logic [12:0] MV_FLASH3 = 13'd4600;
    localparam logic [12:0] MV_FLASH4 = 13'd4400;
    localparam logic [12:0] MV_FLASH5 = 13'd4200;
    localparam logic [12:0] MV_FLASH6 = 13'd4000;

    localparam logic [7:0] CH_R     = 8'h72;
    localparam logic [7:0] CH_X     = 8'h78;
    localparam logic [7:0] CH_CR    = 8'h0D;
    localparam logic [7:0] CH_LF    = 8'h0A;
    localparam logic [7:0] CH_COMMA = 8'h2C;
    localparam logic [7:0] CH_DOT   = 8'h2E;
    localparam logic [7:0] CH_MINUS = 8'h2D;
    localparam logic [7:0] CH_SPACE = 8'h20;
    localparam logic [7:0] CH_M     = 8'h6D;
    localparam logic [7:0] CH_H     = 8'h48;
    localparam logic [7:0] CH_Z     = 8'h7A;
    localparam logic [7:0] CH_C     = 8'h63;
    localparam logic [7:0] CH_S     = 8'h73;
    localparam logic [7:0] CH_CELS  = 8'h43;

    localparam int NUM_DIGITS = 38;
    localparam int REPLY_LEN  = 57;

    typedef enum logic [2:0] {
        SBL_HOST  = 3'b000,
        SBL_BOOT  = 3'b001,
        SBL_READ  = 3'b011,
        SBL_FLASH = 3'b010,
        SBL_SLEEP = 3'b110,
        SBL_WAKE  = 3'b111
    } sbl_state_e;
endpackage

// file: sbl_uart_rx.sv
// serial byte receiver, 8N1
`timescale 1ns/1ns
module sbl_uart_rx #(
    parameter int DIV = sbl_pkg::BAUD_DIV
) (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       rxd,
    output logic [7:0]      rx_data,
    output logic            rx_valid
);
    logic        busy_reg;
    logic [3:0]  bit_reg;
    logic [15:0] cnt_reg;
    logic [7:0]  sh_reg;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            busy_reg <= 1'b0;
            bit_reg  <= 4'h0;
            cnt_reg  <= 16'h0;
            sh_reg   <= 8'h00;
            rx_data  <= 8'h00;
            rx_valid <= 1'b0;
        end
        else
        begin
            rx_valid <= 1'b0;
            if (!busy_reg)
            begin
                if (!rxd)
                begin
                    busy_reg <= 1'b1;
                    cnt_reg  <= 16'(DIV / 2);
                    bit_reg  <= 4'h0;
                end
            end
            else if (cnt_reg != 16'h0)
                cnt_reg <= cnt_reg - 16'h1;
            else
            begin
                cnt_reg <= 16'(DIV - 1);
                bit_reg <= bit_reg + 4'h1;
                // a start bit gone high at mid-bit was a glitch
                if (bit_reg == 4'h0 && rxd)
                    busy_reg <= 1'b0;
                else if (bit_reg == 4'h9)
                begin
                    busy_reg <= 1'b0;
                    if (rxd)
                    begin
                        rx_data  <= sh_reg;
                        rx_valid <= 1'b1;
                    end
                end
                else if (bit_reg != 4'h0)
                    sh_reg <= {rxd, sh_reg[7:1]};
            end
        end
    end
endmodule // sbl_uart_rx

// file: sbl_uart_tx.sv
// serial byte transmitter, 8N1
`timescale 1ns/1ns
module sbl_uart_tx #(
    parameter int DIV = sbl_pkg::BAUD_DIV
) (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    output logic            txd
);
    logic        busy_reg;
    logic [3:0]  bit_reg;
    logic [15:0] cnt_reg;
    logic [9:0]  sh_reg;

    assign tx_ready = !busy_reg;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            busy_reg <= 1'b0;
            bit_reg  <= 4'h0;
            cnt_reg  <= 16'h0;
            sh_reg   <= 10'h3FF;
            txd      <= 1'b1;
        end
        else if (!busy_reg)
        begin
            txd <= 1'b1;
            if (tx_valid)
            begin
                busy_reg <= 1'b1;
                sh_reg   <= {1'b1, tx_data, 1'b0};
                bit_reg  <= 4'h0;
                cnt_reg  <= 16'h0;
            end
        end
        else if (cnt_reg != 16'h0)
            cnt_reg <= cnt_reg - 16'h1;
        else if (bit_reg == 4'hA)
            busy_reg <= 1'b0;
        else
        begin
            txd     <= sh_reg[0];
            sh_reg  <= {1'b1, sh_reg[9:1]};
            bit_reg <= bit_reg + 4'h1;
            cnt_reg <= 16'(DIV - 1);
        end
    end
endmodule // sbl_uart_tx

// file: sbl_sequencer.sv
// battery log LED sequencer with serial reading reply
// What this block does
// - on battery power-up, LED lit three seconds, sensors powered, firmware update allowed
// - store a record only if scheduled and light exceeds threshold
// - reading takes about 8 s, extended up to 300 s before giving up
// - shutdown flashes: one above 4.9 V, two to six for lower levels
// - battery voltage for flash code sampled at reading end under load
// - wake each minute, decide on recording, then repeat the flash code
// - on minute wake, LED starts full and fades off within one second
// - no LED flashing in seconds-interval logging mode
// - LED sequence runs only on battery, not host power
// - commands and replies are serial bytes at 115200 baud
// - reading request ending in CR answered with one comma-separated line
`timescale 1ns/1ns
module sbl_sequencer #(
    parameter int TICK_CYC    = sbl_pkg::MS_CYC,
    parameter int BOOT_MS     = sbl_pkg::BOOT_MS,
    parameter int READ_MIN_MS = sbl_pkg::READ_MIN_MS,
    parameter int READ_MAX_MS = sbl_pkg::READ_MAX_MS,
    parameter int FADE_MS     = sbl_pkg::FADE_MS,
    parameter int FLASH_MS    = sbl_pkg::FLASH_MS,
    parameter int BAUD_DIV    = sbl_pkg::BAUD_DIV,
    parameter int LW          = 24
) (
    input  wire logic                          clk_sys,
    input  wire logic                          rst,
    input  wire logic                          on_battery,
    input  wire logic                          minute_tick,
    input  wire logic                          seconds_mode,
    input  wire logic                          sched_due,
    input  wire logic                          light_valid,
    input  wire logic [LW-1:0]                 light_value,
    input  wire logic [LW-1:0]                 light_threshold,
    input  wire logic [12:0]                   batt_mv,
    input  wire logic [4*sbl_pkg::NUM_DIGITS-1:0] rdg_digits,
    input  wire logic                          mag_neg,
    input  wire logic                          temp_neg,
    input  wire logic                          rxd,
    output logic                               txd,
    output logic                               led,
    output logic                               sensor_pwr,
    output logic                               fw_update_en,
    output logic                               meas_load,
    output logic                               store_rec,
    output logic                               sleep_en,
    output logic [2:0]                         batt_flashes
);
    localparam int FSTEP = (FADE_MS / 256 > 0) ? FADE_MS / 256 : 1;

    sbl_pkg::sbl_state_e state_reg;
    sbl_pkg::sbl_state_e state_next;
    logic [16:0] tick_cnt_reg;
    logic        ms_tick;
    logic [18:0] ms_cnt_reg;
    logic        ms_clr;
    logic        flash_on_reg;
    logic [2:0]  flash_left_reg;
    logic        flash_end;
    logic        read_end;
    logic [7:0]  bright_reg;
    logic [7:0]  pwm_reg;
    logic [9:0]  fstep_reg;
    logic        led_next;

    function automatic logic [2:0] flash_count(input logic [12:0] mv);
        if (mv > sbl_pkg::MV_FLASH1)
            return 3'd1;
        else if (mv > sbl_pkg::MV_FLASH2)
            return 3'd2;
        else if (mv > sbl_pkg::MV_FLASH3)
            return 3'd3;
        else if (mv > sbl_pkg::MV_FLASH4)
            return 3'd4;
        else if (mv > sbl_pkg::MV_FLASH5)
            return 3'd5;
        else
            return 3'd6;
    endfunction

    function automatic logic ms_at(input logic [18:0] cnt, input int lim);
        return cnt == 19'(lim - 1);
    endfunction

    // millisecond enable pulse
    always_ff @(posedge clk_sys)
    begin
        if (rst || tick_cnt_reg == 17'(TICK_CYC - 1))
            tick_cnt_reg <= 17'h0;
        else
            tick_cnt_reg <= tick_cnt_reg + 17'h1;
    end
    assign ms_tick = tick_cnt_reg == 17'(TICK_CYC - 1);

    assign flash_end = ms_tick && ms_at(ms_cnt_reg, FLASH_MS);
    assign read_end  = ms_tick && ((ms_cnt_reg >= 19'(READ_MIN_MS - 1) && light_valid)
                       || ms_at(ms_cnt_reg, READ_MAX_MS));
    assign ms_clr    = (state_next != state_reg) || (state_reg == sbl_pkg::SBL_FLASH && flash_end);

    always_ff @(posedge clk_sys)
    begin
        if (rst || ms_clr)
            ms_cnt_reg <= 19'h0;
        else if (ms_tick)
            ms_cnt_reg <= ms_cnt_reg + 19'h1;
    end

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            sbl_pkg::SBL_HOST:
                if (on_battery)
                    state_next = sbl_pkg::SBL_BOOT;
            sbl_pkg::SBL_BOOT:
                if (ms_tick && ms_at(ms_cnt_reg, BOOT_MS))
                    state_next = sbl_pkg::SBL_READ;
            sbl_pkg::SBL_READ:
                if (read_end)
                    state_next = sbl_pkg::SBL_FLASH;
            sbl_pkg::SBL_FLASH:
                if (flash_end && !flash_on_reg && flash_left_reg == 3'd0)
                    state_next = sbl_pkg::SBL_SLEEP;
            sbl_pkg::SBL_SLEEP:
                if (minute_tick)
                    state_next = sbl_pkg::SBL_WAKE;
            sbl_pkg::SBL_WAKE:
                if (ms_tick && ms_at(ms_cnt_reg, FADE_MS))
                    state_next = sched_due ? sbl_pkg::SBL_READ : sbl_pkg::SBL_FLASH;
        endcase
        // host power ends the sequence at once
        if (!on_battery)
            state_next = sbl_pkg::SBL_HOST;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            state_reg <= sbl_pkg::SBL_HOST;
        else
            state_reg <= state_next;
    end

    // record decision and battery sample at the close of reading
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            store_rec    <= 1'b0;
            batt_flashes <= 3'd1;
        end
        else
        begin
            store_rec <= 1'b0;
            if (state_reg == sbl_pkg::SBL_READ && read_end && on_battery)
            begin
                store_rec    <= light_valid && sched_due
                                && light_value > light_threshold;
                batt_flashes <= flash_count(batt_mv);
            end
        end
    end

    // quick flash counter, on and off phases of equal length
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            flash_on_reg   <= 1'b0;
            flash_left_reg <= 3'd0;
        end
        else if (state_reg != sbl_pkg::SBL_FLASH)
        begin
            flash_on_reg   <= 1'b1;
            // the latched count lands on the same edge as the move to flashing
            flash_left_reg <= (state_reg == sbl_pkg::SBL_READ && read_end)
                              ? flash_count(batt_mv) : batt_flashes;
        end
        else if (flash_end)
        begin
            if (flash_on_reg)
            begin
                flash_on_reg   <= 1'b0;
                flash_left_reg <= flash_left_reg - 3'd1;
            end
            else if (flash_left_reg != 3'd0)
                flash_on_reg <= 1'b1;
        end
    end

    // fade: brightness steps down every few ms, done well inside the second
    always_ff @(posedge clk_sys)
    begin
        if (rst || state_reg != sbl_pkg::SBL_WAKE)
        begin
            bright_reg <= 8'hFF;
            fstep_reg  <= 10'h0;
        end
        else if (ms_tick)
        begin
            if (fstep_reg == 10'(FSTEP - 1))
            begin
                fstep_reg <= 10'h0;
                if (bright_reg != 8'h00)
                    bright_reg <= bright_reg - 8'h01;
            end
            else
                fstep_reg <= fstep_reg + 10'h1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            pwm_reg <= 8'h00;
        else
            pwm_reg <= pwm_reg + 8'h01;
    end

    always_comb
    begin
        led_next = 1'b0;
        unique case (state_reg)
            sbl_pkg::SBL_BOOT:
                led_next = 1'b1;
            sbl_pkg::SBL_FLASH:
                led_next = flash_on_reg && !seconds_mode;
            sbl_pkg::SBL_WAKE:
                led_next = (pwm_reg < bright_reg) && !seconds_mode;
            sbl_pkg::SBL_HOST,
            sbl_pkg::SBL_READ,
            sbl_pkg::SBL_SLEEP:
                led_next = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            led          <= 1'b0;
            sensor_pwr   <= 1'b0;
            fw_update_en <= 1'b0;
            meas_load    <= 1'b0;
            sleep_en     <= 1'b0;
        end
        else
        begin
            led          <= led_next;
            sensor_pwr   <= state_next == sbl_pkg::SBL_BOOT
                            || state_next == sbl_pkg::SBL_READ;
            fw_update_en <= state_next == sbl_pkg::SBL_BOOT;
            meas_load    <= state_next == sbl_pkg::SBL_READ;
            sleep_en     <= state_next == sbl_pkg::SBL_SLEEP;
        end
    end

    // serial command and reply
    logic [7:0] rx_data;
    logic       rx_valid;
    logic [7:0] tx_data;
    logic       tx_ready;
    logic       rep_busy_reg;
    logic [5:0] rep_pos_reg;
    logic [7:0] prev1_reg;
    logic [7:0] prev2_reg;
    logic [4*sbl_pkg::NUM_DIGITS-1:0] rep_dig_reg;
    logic       rep_mneg_reg;
    logic       rep_tneg_reg;

    function automatic logic [7:0] dch(input logic [4*sbl_pkg::NUM_DIGITS-1:0] d,
                                       input int idx);
        return {4'h3, d[idx*4 +: 4]};
    endfunction

    function automatic logic [7:0] reply_char(input int p,
                                              input logic [4*sbl_pkg::NUM_DIGITS-1:0] d,
                                              input logic mn,
                                              input logic tn);
        case (p) inside
            0:        return sbl_pkg::CH_R;
            1, 9, 22, 34, 47:
                      return sbl_pkg::CH_COMMA;
            2:        return mn ? sbl_pkg::CH_MINUS : sbl_pkg::CH_SPACE;
            [3:4]:    return dch(d, p - 3);
            5, 42, 52:
                      return sbl_pkg::CH_DOT;
            [6:7]:    return dch(d, p - 4);
            8:        return sbl_pkg::CH_M;
            [10:19]:  return dch(d, p - 6);
            20:       return sbl_pkg::CH_H;
            21:       return sbl_pkg::CH_Z;
            [23:32]:  return dch(d, p - 9);
            33:       return sbl_pkg::CH_C;
            [35:41]:  return dch(d, p - 11);
            [43:45]:  return dch(d, p - 12);
            46:       return sbl_pkg::CH_S;
            48:       return tn ? sbl_pkg::CH_MINUS : sbl_pkg::CH_SPACE;
            [49:51]:  return dch(d, p - 15);
            53:       return dch(d, p - 16);
            54:       return sbl_pkg::CH_CELS;
            55:       return sbl_pkg::CH_CR;
            default:  return sbl_pkg::CH_LF;
        endcase
    endfunction

    sbl_uart_rx #(.DIV(BAUD_DIV)) u_rx (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .rxd      (rxd),
        .rx_data  (rx_data),
        .rx_valid (rx_valid)
    );

    // a request landing during a reply is dropped; host waits for the line
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            prev1_reg    <= 8'h00;
            prev2_reg    <= 8'h00;
            rep_busy_reg <= 1'b0;
            rep_pos_reg  <= 6'h0;
            rep_dig_reg  <= '0;
            rep_mneg_reg <= 1'b0;
            rep_tneg_reg <= 1'b0;
        end
        else
        begin
            if (rx_valid)
            begin
                if (rx_data == sbl_pkg::CH_CR)
                begin
                    prev1_reg <= 8'h00;
                    prev2_reg <= 8'h00;
                    if (prev2_reg == sbl_pkg::CH_R && prev1_reg == sbl_pkg::CH_X
                        && !rep_busy_reg)
                    begin
                        rep_busy_reg <= 1'b1;
                        rep_pos_reg  <= 6'h0;
                        rep_dig_reg  <= rdg_digits;
                        rep_mneg_reg <= mag_neg;
                        rep_tneg_reg <= temp_neg;
                    end
                end
                else
                begin
                    prev2_reg <= prev1_reg;
                    prev1_reg <= rx_data;
                end
            end
            if (rep_busy_reg && tx_ready)
            begin
                rep_pos_reg <= rep_pos_reg + 6'h1;
                if (rep_pos_reg == 6'(sbl_pkg::REPLY_LEN - 1))
                    rep_busy_reg <= 1'b0;
            end
        end
    end

    assign tx_data = reply_char(int'(rep_pos_reg), rep_dig_reg,
                                rep_mneg_reg, rep_tneg_reg);

    sbl_uart_tx #(.DIV(BAUD_DIV)) u_tx (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .tx_data  (tx_data),
        .tx_valid (rep_busy_reg),
        .tx_ready (tx_ready),
        .txd      (txd)
    );
endmodule // sbl_sequencer

// file: sbl_sequencer_asserts.sv
// concurrent checks on the ports of the battery log LED sequencer
`timescale 1ns/1ns
module sbl_sequencer_asserts #(
    parameter int TICK_CYC    = 10,
    parameter int BOOT_MS     = 3,
    parameter int READ_MIN_MS = 8,
    parameter int READ_MAX_MS = 30,
    parameter int LW          = 24
) (
    input wire logic          clk_sys,
    input wire logic          rst,
    input wire logic          on_battery,
    input wire logic          seconds_mode,
    input wire logic          sched_due,
    input wire logic          light_valid,
    input wire logic [LW-1:0] light_value,
    input wire logic [LW-1:0] light_threshold,
    input wire logic [12:0]   batt_mv,
    input wire logic          txd,
    input wire logic          led,
    input wire logic          sensor_pwr,
    input wire logic          fw_update_en,
    input wire logic          meas_load,
    input wire logic          store_rec,
    input wire logic          sleep_en,
    input wire logic [2:0]    batt_flashes
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    int         boot_cnt;
    int         read_cnt;
    logic [2:0] code;

    // run lengths of the boot and reading phases, zero while the phase is off
    always_ff @(posedge clk_sys)
    begin
        boot_cnt <= (rst || !fw_update_en) ? 0 : boot_cnt + 1;
        read_cnt <= (rst || !meas_load) ? 0 : read_cnt + 1;
    end

    always_comb
    begin
        code = (batt_mv > sbl_pkg::MV_FLASH1) ? 3'h1 : (batt_mv > sbl_pkg::MV_FLASH2) ? 3'h2 :
               (batt_mv > sbl_pkg::MV_FLASH3) ? 3'h3 : (batt_mv > sbl_pkg::MV_FLASH4) ? 3'h4 :
               (batt_mv > sbl_pkg::MV_FLASH5) ? 3'h5 : 3'h6;
    end

    chk_boot_power: assert property (fw_update_en |-> sensor_pwr && !meas_load)
        else $error("boot phase without sensor power");
    chk_boot_len: assert property ($fell(fw_update_en) && !$past(rst) && on_battery |->
        boot_cnt > (BOOT_MS - 1) * TICK_CYC && boot_cnt <= BOOT_MS * TICK_CYC + 1)
        else $error("boot phase length wrong");
    chk_read_len: assert property ($fell(meas_load) && !$past(rst) && on_battery |->
        read_cnt > (READ_MIN_MS - 1) * TICK_CYC && read_cnt <= READ_MAX_MS * TICK_CYC + 1)
        else $error("reading phase length wrong");
    chk_store_gate: assert property (store_rec |-> $past(meas_load) && $past(sched_due) &&
        $past(light_valid) && $past(light_value) > $past(light_threshold))
        else $error("record stored without cause");
    chk_store_pulse: assert property (store_rec |=> !store_rec)
        else $error("store pulse too long");
    chk_flash_code: assert property ($changed(batt_flashes) && !$past(rst) && on_battery &&
        $past(on_battery) |-> $past(meas_load) && batt_flashes == $past(code))
        else $error("flash count not latched from loaded voltage");
    chk_host_dark: assert property (!on_battery [*2] |=> !led && !sensor_pwr &&
        !fw_update_en && !meas_load && !sleep_en)
        else $error("sequence active on host power");
    chk_sleep_dark: assert property (sleep_en |-> !led && !meas_load)
        else $error("led or load on in sleep");
    chk_wake_bright: assert property ($fell(sleep_en) && on_battery && !seconds_mode |->
        ##[1:4] led)
        else $error("led not lit on wake");
    chk_start_bit: assert property ($fell(txd) |-> !txd [*8])
        else $error("start bit too short");

    cover property (store_rec);
    cover property ($fell(sleep_en));
    cover property (batt_flashes == 3'h6);
    cover property ($fell(fw_update_en));
endmodule // sbl_sequencer_asserts

bind sbl_sequencer sbl_sequencer_asserts #(.TICK_CYC(TICK_CYC), .BOOT_MS(BOOT_MS),
    .READ_MIN_MS(READ_MIN_MS), .READ_MAX_MS(READ_MAX_MS), .LW(LW)) u_chk (.clk_sys, .rst,
    .on_battery, .seconds_mode, .sched_due, .light_valid, .light_value, .light_threshold,
    .batt_mv, .txd, .led, .sensor_pwr, .fw_update_en, .meas_load, .store_rec, .sleep_en,
    .batt_flashes);

// file: sbl_host_model.sv
// host side serial model: sends requests, collects reply bytes
`timescale 1ns/1ns
module sbl_host_model #(
    parameter int DIV = 16
) (
    input  wire logic clk_sys,
    input  wire logic txd,
    output logic      rxd
);
    logic [7:0] rx_q[$];
    logic [7:0] rx_b;

    initial rxd = 1'b1;

    // lsb first, line back to idle high after the stop bit
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            @(negedge clk_sys);
            rxd = f[i];
            repeat (DIV - 1) @(negedge clk_sys);
        end
    endtask

    // caller collects the whole reply before the next request
    task automatic send_req(input logic [7:0] cmd);
        send_byte(8'h72);
        send_byte(cmd);
        send_byte(8'h0D);
    endtask

    // mid-cell sampling on the falling edge keeps clear of txd updates
    initial
    begin
        forever
        begin
            @(negedge txd);
            repeat (DIV / 2) @(negedge clk_sys);
            if (!txd)
            begin
                for (int i = 0; i < 8; i++)
                begin
                    repeat (DIV) @(negedge clk_sys);
                    rx_b[i] = txd;
                end
                repeat (DIV) @(negedge clk_sys);
                if (txd) rx_q.push_back(rx_b);
            end
        end
    end
endmodule // sbl_host_model

// file: sbl_sequencer_tb_top.sv
// self-checking bench for the battery log LED sequencer
`timescale 1ns/1ns
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin mismatches++; \
    $display("Error %0t: got %0h want %0h", $time, (a), (e)); end end
`define WAITF(c, n) begin for (int k = 0; k < (n) && !(c); k++) @(negedge clk_sys); \
    if (!(c)) begin mismatches++; $display("Error %0t: wait ran out", $time); final_report(); end end
module sbl_sequencer_tb_top;
    localparam int TICK = 1;
    localparam int FL   = sbl_pkg::FLASH_MS;
    logic         clk_sys, rst, on_battery, minute_tick, seconds_mode, sched_due, light_valid;
    logic [23:0]  light_value, light_threshold;
    logic [12:0]  batt_mv;
    logic [151:0] rdg_digits;
    logic         mag_neg, temp_neg, rxd, txd, led, sensor_pwr, fw_update_en, meas_load;
    logic         store_rec, sleep_en;
    logic [2:0]   batt_flashes;
    int           mismatches, samples_checked, n_led, w_led, n_store, w_read;
    logic [12:0]  mv_tab [6] = '{13'h1325, 13'h1324, 13'h125C, 13'h11F8, 13'h10CC, 13'h1068};

    sbl_sequencer #(.TICK_CYC(TICK), .READ_MIN_MS(8), .READ_MAX_MS(30), .BAUD_DIV(16))
        u_sbl_sequencer (.clk_sys, .rst,
        .on_battery, .minute_tick, .seconds_mode, .sched_due, .light_valid, .light_value,
        .light_threshold, .batt_mv, .rdg_digits, .mag_neg, .temp_neg, .rxd, .txd, .led,
        .sensor_pwr, .fw_update_en, .meas_load, .store_rec, .sleep_en, .batt_flashes);
    sbl_host_model u_sbl_host_model (.clk_sys, .txd, .rxd);

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic host_reply();
        on_battery = 1'b0;
        mag_neg = 1'b1;
        temp_neg = 1'b1;
        for (int i = 0; i < 38; i++) rdg_digits[4*i +: 4] = 4'(i % 10);
        u_sbl_host_model.send_req(8'h78);
        `WAITF(u_sbl_host_model.rx_q.size() == 57, 12000)
        `CHK(u_sbl_host_model.rx_q[0], 8'h72);
        `CHK(u_sbl_host_model.rx_q[2], 8'h2D);
        `CHK(u_sbl_host_model.rx_q[4], 8'h31);
        `CHK(u_sbl_host_model.rx_q[5], 8'h2E);
        `CHK(u_sbl_host_model.rx_q[48], 8'h2D);
        `CHK(u_sbl_host_model.rx_q[55], 8'h0D);
        `CHK(u_sbl_host_model.rx_q[56], 8'h0A);
        `CHK(led, 1'b0);
        u_sbl_host_model.rx_q.delete();
        u_sbl_host_model.send_req(8'h7A);
        repeat (400) @(negedge clk_sys);
        `CHK(u_sbl_host_model.rx_q.size(), 0);
    endtask

    task automatic power_up();
        on_battery = 1'b1;
        `WAITF(fw_update_en, 10)
        `CHK(sensor_pwr, 1'b1);
        @(negedge clk_sys);
        `CHK(led, 1'b1);
    endtask

    task automatic wake();
        minute_tick = 1'b1;
        @(negedge clk_sys);
        minute_tick = 1'b0;
    endtask

    // one reading, flash code and return to sleep
    task automatic run_log(input int exp_led, input logic [2:0] exp_code, input int exp_st);
        logic prev;
        n_led = 0;
        w_led = 0;
        n_store = 0;
        w_read = 0;
        prev = 1'b0;
        `WAITF(meas_load, 3200)
        while (meas_load && w_read < 4000)
        begin
            w_read++;
            n_store += int'(store_rec);
            @(negedge clk_sys);
        end
        for (int k = 0; k < 2000 && !sleep_en; k++)
        begin
            n_store += int'(store_rec);
            if (led && !prev) n_led++;
            if (led && n_led == 1) w_led++;
            prev = led;
            @(negedge clk_sys);
        end
        `CHK(sleep_en, 1'b1);
        `CHK(n_led, exp_led);
        `CHK(batt_flashes, exp_code);
        `CHK(n_store, exp_st);
        if (exp_led != 0) `CHK(w_led > TICK * (FL - 1) && w_led <= TICK * FL, 1'b1);
    endtask

    task automatic flash_codes();
        for (int i = 0; i < 6; i++)
        begin
            batt_mv = mv_tab[i];
            wake();
            run_log(i + 1, 3'(i + 1), 1);
        end
    endtask

    task automatic gates_and_modes();
        light_threshold = 24'h000005;
        wake();
        run_log(6, 3'h6, 0);
        light_valid = 1'b0;
        wake();
        run_log(6, 3'h6, 0);
        `CHK(w_read >= (30 - 1) * TICK, 1'b1);
        light_valid = 1'b1;
        light_value = 24'h000006;
        seconds_mode = 1'b1;
        wake();
        run_log(0, 3'h6, 1);
        seconds_mode = 1'b0;
    endtask

    task automatic replug_unscheduled();
        on_battery = 1'b0;
        repeat (5) @(negedge clk_sys);
        `CHK(sleep_en, 1'b0);
        sched_due = 1'b0;
        power_up();
        run_log(6, 3'h6, 0);
    endtask

    initial
    begin
        rst = 1'b1;
        on_battery = 1'b0;
        minute_tick = 1'b0;
        seconds_mode = 1'b0;
        sched_due = 1'b1;
        light_valid = 1'b1;
        light_value = 24'h000005;
        light_threshold = 24'h000004;
        batt_mv = 13'h1325;
        mag_neg = 1'b0;
        temp_neg = 1'b0;
        repeat (3) @(negedge clk_sys);
        rst = 1'b0;
        `CHK(txd, 1'b1);
        `CHK(batt_flashes, 3'h1);
        host_reply();
        power_up();
        run_log(1, 3'h1, 1);
        flash_codes();
        gates_and_modes();
        replug_unscheduled();
        final_report();
    end
endmodule // sbl_sequencer_tb_top
